// file: hw/pin_value_a_defines.svh
// Constants for the port A block: register offsets, field positions,
// reset values and bit-modify encodings.
// Assumes it is included by its bare name; the include guard makes repeat inclusion harmless.
`ifndef PIN_VALUE_A_DEFINES_SVH
`define PIN_VALUE_A_DEFINES_SVH

// ******************************************************************
// Geometry
// ******************************************************************
`define PA_LINES 6
`define PA_ADDR_W 3
`define PA_DATA_W 8
`define PA_INPUT_ONLY_LINE 3
`define PA_LINE_FOUR 4
`define PA_LINE_FIVE 5
`define PA_HI_PRIO_FOUR 4

// ******************************************************************
// Register offsets
// ******************************************************************
`define PA_ADDR_PIN_VALUE 3'h0
`define PA_ADDR_LATCH 3'h1
`define PA_ADDR_DIRECTION 3'h2
`define PA_ADDR_ANALOG 3'h3
`define PA_ADDR_INPUT_LEVEL 3'h4
`define PA_ADDR_ALT_PIN 3'h5
`define PA_ADDR_BIT_MODIFY 3'h6

// ******************************************************************
// Reset values
// ******************************************************************
`define PA_RST_LATCH 6'h00
`define PA_RST_DIRECTION 6'h3F
`define PA_RST_ANALOG 6'h3F
`define PA_RST_INPUT_LEVEL 6'h00
`define PA_RST_ALT_PIN 6'h00
`define PA_ALT_PIN_W 6

// ******************************************************************
// Fields of alternate_pin_select_0
// ******************************************************************
`define PA_APF_SERIAL_OUT2 5
`define PA_APF_SLAVE_SELECT2 4
`define PA_APF_ECCP1_D 3
`define PA_APF_ECCP1_C 2
`define PA_APF_ECCP2_B 1
`define PA_APF_CAPTURE2 0

// ******************************************************************
// Bit-modify register: operation in [7:6], line index in [2:0]
// ******************************************************************
`define PA_BM_OP_HI 7
`define PA_BM_OP_LO 6
`define PA_BM_IDX_HI 2
`define PA_BM_OP_CLEAR 2'h0
`define PA_BM_OP_SET 2'h1
`define PA_BM_OP_TOGGLE 2'h2
`define PA_BM_OP_COPY 2'h3

`endif

// file: hw/pin_value_a_pkg.sv
// Types shared by the port A block.
// Assumes pin_value_a_defines.svh is on the include path.
`include "pin_value_a_defines.svh"

package pin_value_a_pkg;

   // ******************************************************************
   // Whole state of the port block, registered in one place
   // ******************************************************************
   typedef struct packed {
      logic [`PA_LINES-1:0] latch_r;
      logic [`PA_LINES-1:0] direction_r;
      logic [`PA_LINES-1:0] analog_r;
      logic [`PA_LINES-1:0] input_level_r;
      logic [`PA_ALT_PIN_W-1:0] alt_pin_r;
      logic [`PA_DATA_W-1:0] rdata_r;
      logic [`PA_LINES-1:0] in_prev_r;
      logic [`PA_LINES-1:0] change_r;
      logic [`PA_LINES-1:0] pin_out_r;
      logic [`PA_LINES-1:0] pin_oe_r;
      logic portc2_val_r;
      logic portc2_en_r;
      logic cap2_dflt_val_r;
      logic cap2_dflt_en_r;
   } pin_value_a_state_t;

endpackage

// file: hw/pin_value_a_input_slice.sv
// One port line's input path: threshold choice and analog masking.
// Assumes both comparator results arrive synchronous to the system clock.
`timescale 1ns/1ps

module pin_value_a_input_slice (
   input wire logic schmitt_in,
   input wire logic ttl_in,
   input wire logic level_sel,
   input wire logic analog_sel,
   output logic digital_in
);

   // The chosen threshold feeds both the read path and change detection,
   // so a threshold switch can itself look like an edge on the line.
   always_comb begin
      if (analog_sel) begin
         digital_in = 1'b0;
      end else if (level_sel) begin
         digital_in = ttl_in;
      end else begin
         digital_in = schmitt_in;
      end
   end

endmodule

// file: hw/pin_value_a_output_steer.sv
// Output steering and priority for the lines that carry peripheral signals.
// Assumes peripheral value/enable pairs are synchronous to the system clock.
`timescale 1ns/1ps
`include "pin_value_a_defines.svh"

module pin_value_a_output_steer #(
   parameter int HI_PRIO = `PA_HI_PRIO_FOUR
) (
   input wire logic eccp2_b_pin_select,
   input wire logic capture2_pin_select,
   input wire logic [HI_PRIO-1:0] line_four_prio_en,
   input wire logic [HI_PRIO-1:0] line_four_prio_val,
   input wire logic eccp2_output_b,
   input wire logic eccp2_output_b_en,
   input wire logic capture2_out,
   input wire logic capture2_en,
   output logic line_four_en,
   output logic line_four_val,
   output logic line_five_en,
   output logic line_five_val,
   output logic portc_line_two_en,
   output logic portc_line_two_val,
   output logic cap2_dflt_en,
   output logic cap2_dflt_val
);

   // Line four: the lowest index of the higher group wins, the steered
   // ECCP2 B output only gets the pin when none of them is enabled.
   always_comb begin
      line_four_en = eccp2_b_pin_select & eccp2_output_b_en;
      line_four_val = eccp2_output_b;
      for (int k = HI_PRIO - 1; k >= 0; k--) begin
         if (line_four_prio_en[k]) begin
            line_four_en = 1'b1;
            line_four_val = line_four_prio_val[k];
         end
      end
   end

   // The unselected pin sees nothing of the steered signal.
   always_comb begin
      portc_line_two_en = ~eccp2_b_pin_select & eccp2_output_b_en;
      portc_line_two_val = eccp2_output_b & ~eccp2_b_pin_select;
      line_five_en = capture2_pin_select & capture2_en;
      line_five_val = capture2_out & capture2_pin_select;
      cap2_dflt_en = ~capture2_pin_select & capture2_en;
      cap2_dflt_val = capture2_out & ~capture2_pin_select;
   end

endmodule

// file: hw/pin_value_a_io.sv
// Port A general-purpose I/O with direction, latch, analog select,
// threshold select and the first alternate pin steering register.
// Assumes the register master follows the single-cycle strobe protocol
// and that pin comparator inputs are synchronous to clk_sys.
`timescale 1ns/1ps
`include "pin_value_a_defines.svh"

// Operation
// - Six lines, five of them bidirectional, each with direction bit and output latch bit.
// - Direction bit one turns the line's driver off; line is input.
// - Direction bit zero turns the driver on with the latch value.
// - Line three is input only; its direction bit reads one always.
// - Pin value read returns pins; a write lands in the latch.
// - Writes are read-modify-write: pins read, modified, stored in latch; here only bit-modify writes do so, pin value writes store wdata.
// - Direction keeps driver control even on analog-selected lines.
// - Analog-selected lines read zero digitally; analog functions may run.
// - Analog select leaves digital output untouched; driving continues.
// - Reset puts every line into analog input mode.
// - Per-line threshold select: Schmitt or TTL, for reads and changes.
// - ECCP2 B goes to port C line two, or line four when set.
// - Steering never touches direction; unselected pin stays unaffected.
// - Several outputs on one pin: highest listed priority owns it.
module pin_value_a_io #(
   parameter int LINES = `PA_LINES,
   parameter int HI_PRIO = `PA_HI_PRIO_FOUR
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [`PA_ADDR_W-1:0] addr,
   input wire logic [`PA_DATA_W-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [`PA_DATA_W-1:0] rdata,
   input wire logic [LINES-1:0] pin_schmitt_in,
   input wire logic [LINES-1:0] pin_ttl_in,
   output logic [LINES-1:0] pin_out,
   output logic [LINES-1:0] pin_oe,
   output logic [LINES-1:0] analog_enable,
   output logic [LINES-1:0] input_change,
   input wire logic [HI_PRIO-1:0] line_four_prio_en,
   input wire logic [HI_PRIO-1:0] line_four_prio_val,
   input wire logic eccp2_output_b,
   input wire logic eccp2_output_b_en,
   input wire logic capture2_out,
   input wire logic capture2_en,
   output logic portc_line_two_out,
   output logic portc_line_two_en,
   output logic capture2_dflt_out,
   output logic capture2_dflt_en,
   output logic serial_out2_pin_select,
   output logic slave_select2_pin_select,
   output logic eccp1_d_pin_select,
   output logic eccp1_c_pin_select,
   output logic eccp2_b_pin_select,
   output logic capture2_pin_select
);

   // ******************************************************************
   // Local constants
   // ******************************************************************
   localparam logic [LINES-1:0] INPUT_ONLY_MASK = LINES'(1) << `PA_INPUT_ONLY_LINE;
   localparam logic [`PA_DATA_W-LINES-1:0] PAD_ZERO = '0;

   // ******************************************************************
   // State and conditioned inputs
   // ******************************************************************
   pin_value_a_pkg::pin_value_a_state_t st_r;
   pin_value_a_pkg::pin_value_a_state_t st_nxt;
   logic [LINES-1:0] pin_read;
   logic line_four_en;
   logic line_four_val;
   logic line_five_en;
   logic line_five_val;
   logic portc2_en;
   logic portc2_val;
   logic cap2_en;
   logic cap2_val;
   logic [1:0] bm_op;
   logic [`PA_BM_IDX_HI:0] bm_idx;
   logic [LINES-1:0] bm_mask;
   logic [LINES-1:0] bm_result;
   logic [LINES-1:0] ovr_en;
   logic [LINES-1:0] ovr_val;

   // ******************************************************************
   // Per-line input conditioning
   // ******************************************************************
   // Each line picks its threshold and is masked to zero when analog.
   generate
      for (genvar i = 0; i < LINES; i++) begin : g_line
         pin_value_a_input_slice u_slice (
            .schmitt_in(pin_schmitt_in[i]),
            .ttl_in(pin_ttl_in[i]),
            .level_sel(st_r.input_level_r[i]),
            .analog_sel(st_r.analog_r[i]),
            .digital_in(pin_read[i])
         );
      end
   endgenerate

   // ******************************************************************
   // Peripheral output steering
   // ******************************************************************
   pin_value_a_output_steer #(
      .HI_PRIO(HI_PRIO)
   ) u_steer (
      .eccp2_b_pin_select(st_r.alt_pin_r[`PA_APF_ECCP2_B]),
      .capture2_pin_select(st_r.alt_pin_r[`PA_APF_CAPTURE2]),
      .line_four_prio_en(line_four_prio_en),
      .line_four_prio_val(line_four_prio_val),
      .eccp2_output_b(eccp2_output_b),
      .eccp2_output_b_en(eccp2_output_b_en),
      .capture2_out(capture2_out),
      .capture2_en(capture2_en),
      .line_four_en(line_four_en),
      .line_four_val(line_four_val),
      .line_five_en(line_five_en),
      .line_five_val(line_five_val),
      .portc_line_two_en(portc2_en),
      .portc_line_two_val(portc2_val),
      .cap2_dflt_en(cap2_en),
      .cap2_dflt_val(cap2_val)
   );

   // Only lines four and five carry steered outputs in this block; the
   // rest always show their latch.
   always_comb begin
      ovr_en = '0;
      ovr_val = '0;
      ovr_en[`PA_LINE_FOUR] = line_four_en;
      ovr_val[`PA_LINE_FOUR] = line_four_val;
      ovr_en[`PA_LINE_FIVE] = line_five_en;
      ovr_val[`PA_LINE_FIVE] = line_five_val;
   end

   // ******************************************************************
   // Bit-modify decode
   // ******************************************************************
   // The modify starts from the pins as read, not from the latch, so an
   // analog line or an input held low by the board comes back as zero.
   always_comb begin
      bm_op = wdata[`PA_BM_OP_HI:`PA_BM_OP_LO];
      bm_idx = wdata[`PA_BM_IDX_HI:0];
      bm_mask = '0;
      if (32'(bm_idx) < LINES) begin
         bm_mask = LINES'(1) << bm_idx;
      end
      case (bm_op)
         `PA_BM_OP_CLEAR: bm_result = pin_read & ~bm_mask;
         `PA_BM_OP_SET: bm_result = pin_read | bm_mask;
         `PA_BM_OP_TOGGLE: bm_result = pin_read ^ bm_mask;
         default: bm_result = pin_read;
      endcase
   end

   // ******************************************************************
   // Next state
   // ******************************************************************
   always_comb begin
      st_nxt = st_r;

      // Register writes; the latch of the input-only line is not stored.
      if (wr_stb) begin
         case (addr)
            `PA_ADDR_PIN_VALUE: begin
               st_nxt.latch_r = wdata[LINES-1:0] & ~INPUT_ONLY_MASK;
            end
            `PA_ADDR_LATCH: begin
               st_nxt.latch_r = wdata[LINES-1:0] & ~INPUT_ONLY_MASK;
            end
            `PA_ADDR_DIRECTION: begin
               st_nxt.direction_r = wdata[LINES-1:0] | INPUT_ONLY_MASK;
            end
            `PA_ADDR_ANALOG: begin
               st_nxt.analog_r = wdata[LINES-1:0];
            end
            `PA_ADDR_INPUT_LEVEL: begin
               st_nxt.input_level_r = wdata[LINES-1:0];
            end
            `PA_ADDR_ALT_PIN: begin
               st_nxt.alt_pin_r = wdata[`PA_ALT_PIN_W-1:0];
            end
            `PA_ADDR_BIT_MODIFY: begin
               st_nxt.latch_r = bm_result & ~INPUT_ONLY_MASK;
            end
            default: begin
               st_nxt.latch_r = st_r.latch_r;
            end
         endcase
      end

      // Read data stand for exactly one cycle after the strobe.
      st_nxt.rdata_r = '0;
      if (rd_stb) begin
         case (addr)
            `PA_ADDR_PIN_VALUE: st_nxt.rdata_r = {PAD_ZERO, pin_read};
            `PA_ADDR_LATCH: st_nxt.rdata_r = {PAD_ZERO, st_r.latch_r};
            `PA_ADDR_DIRECTION: begin
               st_nxt.rdata_r = {PAD_ZERO, st_r.direction_r | INPUT_ONLY_MASK};
            end
            `PA_ADDR_ANALOG: st_nxt.rdata_r = {PAD_ZERO, st_r.analog_r};
            `PA_ADDR_INPUT_LEVEL: st_nxt.rdata_r = {PAD_ZERO, st_r.input_level_r};
            `PA_ADDR_ALT_PIN: st_nxt.rdata_r = {2'h0, st_r.alt_pin_r};
            default: st_nxt.rdata_r = '0;
         endcase
      end

      // Change detect on the conditioned input: one-cycle pulse per line.
      st_nxt.in_prev_r = pin_read;
      st_nxt.change_r = pin_read ^ st_r.in_prev_r;

      // Drivers follow the direction bits only; analog select and the
      // steering bits never switch a driver off.
      st_nxt.pin_oe_r = ~st_r.direction_r & ~INPUT_ONLY_MASK;
      for (int i = 0; i < LINES; i++) begin
         if (ovr_en[i]) begin
            st_nxt.pin_out_r[i] = ovr_val[i];
         end else begin
            st_nxt.pin_out_r[i] = st_r.latch_r[i];
         end
      end

      // Steered signals toward port C are registered like every output.
      st_nxt.portc2_val_r = portc2_val;
      st_nxt.portc2_en_r = portc2_en;
      st_nxt.cap2_dflt_val_r = cap2_val;
      st_nxt.cap2_dflt_en_r = cap2_en;
   end

   // ******************************************************************
   // State register
   // ******************************************************************
   // Lines come out of reset analog, inputs, drivers off.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_r.latch_r <= `PA_RST_LATCH;
         st_r.direction_r <= `PA_RST_DIRECTION;
         st_r.analog_r <= `PA_RST_ANALOG;
         st_r.input_level_r <= `PA_RST_INPUT_LEVEL;
         st_r.alt_pin_r <= `PA_RST_ALT_PIN;
         st_r.rdata_r <= '0;
         st_r.in_prev_r <= '0;
         st_r.change_r <= '0;
         st_r.pin_out_r <= '0;
         st_r.pin_oe_r <= '0;
         st_r.portc2_val_r <= 1'b0;
         st_r.portc2_en_r <= 1'b0;
         st_r.cap2_dflt_val_r <= 1'b0;
         st_r.cap2_dflt_en_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ******************************************************************
   // Outputs, all straight from the state register
   // ******************************************************************
   assign rdata = st_r.rdata_r;
   assign pin_out = st_r.pin_out_r;
   assign pin_oe = st_r.pin_oe_r;
   assign analog_enable = st_r.analog_r;
   assign input_change = st_r.change_r;
   assign portc_line_two_out = st_r.portc2_val_r;
   assign portc_line_two_en = st_r.portc2_en_r;
   assign capture2_dflt_out = st_r.cap2_dflt_val_r;
   assign capture2_dflt_en = st_r.cap2_dflt_en_r;

   // Steering selects go to the peripherals and pins outside this block.
   assign serial_out2_pin_select = st_r.alt_pin_r[`PA_APF_SERIAL_OUT2];
   assign slave_select2_pin_select = st_r.alt_pin_r[`PA_APF_SLAVE_SELECT2];
   assign eccp1_d_pin_select = st_r.alt_pin_r[`PA_APF_ECCP1_D];
   assign eccp1_c_pin_select = st_r.alt_pin_r[`PA_APF_ECCP1_C];
   assign eccp2_b_pin_select = st_r.alt_pin_r[`PA_APF_ECCP2_B];
   assign capture2_pin_select = st_r.alt_pin_r[`PA_APF_CAPTURE2];

endmodule

// file: verif/pin_value_a_io_monitor.sv
// Concurrent checks on the port A block, watching only its top-level ports.
// Assumes it is bound into pin_value_a_io and shares its clock and reset.
`timescale 1ns/1ps
`include "pin_value_a_defines.svh"

module pin_value_a_io_monitor #(
   parameter int LINES = `PA_LINES,
   parameter int HI_PRIO = `PA_HI_PRIO_FOUR
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [`PA_ADDR_W-1:0] addr,
   input wire logic [`PA_DATA_W-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [`PA_DATA_W-1:0] rdata,
   input wire logic [LINES-1:0] pin_out,
   input wire logic [LINES-1:0] pin_oe,
   input wire logic [LINES-1:0] analog_enable,
   input wire logic [HI_PRIO-1:0] line_four_prio_en,
   input wire logic [HI_PRIO-1:0] line_four_prio_val,
   input wire logic eccp2_output_b,
   input wire logic eccp2_output_b_en,
   input wire logic capture2_en,
   input wire logic portc_line_two_en,
   input wire logic capture2_dflt_en,
   input wire logic eccp2_b_pin_select,
   input wire logic capture2_pin_select
);
   // ****************************************
   // Checks
   // ****************************************
   // Terms reaching back into reset are guarded by the past reset level.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   chk_oe_line_three: assert property (pin_oe[3] == 1'b0)
      else $error("input only line drives");
   chk_dir_bit_three: assert property (rd_stb && addr == `PA_ADDR_DIRECTION |=> rdata[3])
      else $error("direction bit three reads zero");
   chk_top_bits_zero: assert property (rd_stb |=> rdata[7:6] == 2'h0)
      else $error("top read bits not zero");
   chk_analog_read_zero: assert property (rd_stb && addr == `PA_ADDR_PIN_VALUE
      |=> (rdata[5:0] & $past(analog_enable)) == 6'h00)
      else $error("analog line reads one");
   chk_dir_drives_oe: assert property ((wr_stb && addr == `PA_ADDR_DIRECTION)
      ##1 !(wr_stb && addr == `PA_ADDR_DIRECTION)
      |-> ##1 pin_oe == (~$past(wdata[5:0], 2) & 6'h37))
      else $error("driver enables differ from direction");
   chk_latch_drives_out: assert property ((wr_stb && addr <= `PA_ADDR_LATCH) ##1 !wr_stb
      |-> ##1 pin_out[2:0] == $past(wdata[2:0], 2))
      else $error("pin value differs from latch");
   chk_portc_route: assert property ($past(rstn) |-> portc_line_two_en ==
      ($past(eccp2_output_b_en) && !$past(eccp2_b_pin_select)))
      else $error("port C line two route wrong");
   chk_line_four_eccp: assert property ($past(rstn) && $past(eccp2_b_pin_select)
      && $past(eccp2_output_b_en) && !(|$past(line_four_prio_en))
      |-> pin_out[4] == $past(eccp2_output_b))
      else $error("line four misses steered output");
   chk_prio_top: assert property ($past(rstn) && $past(line_four_prio_en[0])
      |-> pin_out[4] == $past(line_four_prio_val[0]))
      else $error("line four priority wrong");
   chk_cap_default: assert property ($past(rstn) |-> capture2_dflt_en ==
      ($past(capture2_en) && !$past(capture2_pin_select)))
      else $error("capture default route wrong");
   chk_steer_keeps_oe: assert property (wr_stb && addr == `PA_ADDR_ALT_PIN
      |=> ##1 $stable(pin_oe))
      else $error("steering write moved a driver");
endmodule

bind pin_value_a_io pin_value_a_io_monitor #(.LINES(LINES), .HI_PRIO(HI_PRIO)) mon_u (.*);

// file: verif/pin_value_a_board.sv
// Board model for the port A pins: resolves each line, feeds both comparators.
// Assumes the bench sets the board pull levels and a per-line TTL offset.
`timescale 1ns/1ps

module pin_value_a_board #(
   parameter int LINES = 6
) (
   input wire logic [LINES-1:0] pin_out,
   input wire logic [LINES-1:0] pin_oe,
   input wire logic [LINES-1:0] board_level,
   input wire logic [LINES-1:0] ttl_skew,
   output logic [LINES-1:0] pin_schmitt_in,
   output logic [LINES-1:0] pin_ttl_in
);
   logic [LINES-1:0] wire_lvl;
   // A driven line shows the device value; a released one the board pull level.
   assign wire_lvl = (pin_oe & pin_out) | (~pin_oe & board_level);
   // A mid-rail level falls apart on the two thresholds, which skew models.
   assign pin_schmitt_in = wire_lvl;
   assign pin_ttl_in = wire_lvl ^ ttl_skew;
endmodule

// file: verif/pin_value_a_io_tb.sv
// Self-checking bench for the port A block with the board model on its pins.
// Assumes the design and package are compiled before this file.
`timescale 1ns/1ps
`include "pin_value_a_defines.svh"

module pin_value_a_io_tb;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [7:0] rdata;
   logic [5:0] pin_schmitt_in, pin_ttl_in, pin_out, pin_oe, analog_enable, input_change;
   logic [3:0] line_four_prio_en = 4'h0;
   logic [3:0] line_four_prio_val = 4'h0;
   logic eccp2_output_b = 1'b0;
   logic eccp2_output_b_en = 1'b0;
   logic capture2_out = 1'b0;
   logic capture2_en = 1'b0;
   logic portc_line_two_out, portc_line_two_en, capture2_dflt_out, capture2_dflt_en;
   logic serial_out2_pin_select, slave_select2_pin_select, eccp1_d_pin_select;
   logic eccp1_c_pin_select, eccp2_b_pin_select, capture2_pin_select;
   logic [5:0] board_level = 6'h3F;
   logic [5:0] ttl_skew = 6'h00;
   logic [7:0] rd_val;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;

   pin_value_a_io dut_u (.*);
   pin_value_a_board board_u (.*);

   always #20 clk_sys = ~clk_sys;

   // The whole run needs well under a thousand cycles; a hang is cut at 20000.
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         results();
      end
   end

   // ****************************************
   // Bus tasks and comparison
   // ****************************************
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample mid-cycle.
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      @(negedge clk_sys);
      rd_val = rdata;
      check(rd_val, exp);
   endtask

   // Pin outputs follow a register write one edge later.
   task automatic settle();
      repeat (2) @(negedge clk_sys);
   endtask

   task automatic t_reset();
      rd_chk(`PA_ADDR_LATCH, 8'h00);
      rd_chk(`PA_ADDR_DIRECTION, 8'h3F);
      rd_chk(`PA_ADDR_ANALOG, 8'h3F);
      rd_chk(`PA_ADDR_INPUT_LEVEL, 8'h00);
      rd_chk(`PA_ADDR_ALT_PIN, 8'h00);
      rd_chk(3'h7, 8'h00);
      rd_chk(`PA_ADDR_PIN_VALUE, 8'h00);
      check({2'h0, pin_oe}, 8'h00);
      check({2'h0, analog_enable}, 8'h3F);
   endtask

   task automatic t_drive();
      wr(`PA_ADDR_ANALOG, 8'h00);
      wr(`PA_ADDR_DIRECTION, 8'h00);
      wr(`PA_ADDR_LATCH, 8'hFF);
      settle();
      check({2'h0, pin_oe}, 8'h37);
      check({2'h0, pin_out}, 8'h37);
      rd_chk(`PA_ADDR_DIRECTION, 8'h08);
      rd_chk(`PA_ADDR_LATCH, 8'h37);
      rd_chk(`PA_ADDR_PIN_VALUE, 8'h3F);
      wr(`PA_ADDR_LATCH, 8'h00);
      settle();
      rd_chk(`PA_ADDR_PIN_VALUE, 8'h08);
      wr(`PA_ADDR_DIRECTION, 8'h3F);
      settle();
      check({2'h0, pin_oe}, 8'h00);
   endtask

   task automatic t_read();
      @(posedge clk_sys);
      board_level <= 6'h15;
      rd_chk(`PA_ADDR_PIN_VALUE, 8'h15);
      wr(`PA_ADDR_PIN_VALUE, 8'h2A);
      rd_chk(`PA_ADDR_LATCH, 8'h22);
      rd_chk(`PA_ADDR_PIN_VALUE, 8'h15);
      wr(`PA_ADDR_ANALOG, 8'h05);
      rd_chk(`PA_ADDR_PIN_VALUE, 8'h10);
      wr(`PA_ADDR_ANALOG, 8'h00);
      // Thresholds move while every peripheral enable is low.
      ttl_skew <= 6'h03;
      wr(`PA_ADDR_INPUT_LEVEL, 8'h01);
      // Line zero now reads through the skewed threshold, which is itself an edge.
      settle();
      check({2'h0, input_change}, 8'h01);
      rd_chk(`PA_ADDR_INPUT_LEVEL, 8'h01);
      rd_chk(`PA_ADDR_PIN_VALUE, 8'h14);
      wr(`PA_ADDR_INPUT_LEVEL, 8'h00);
      rd_chk(`PA_ADDR_PIN_VALUE, 8'h15);
   endtask

   // Set, toggle, clear, copy and an out-of-range line, each on the pins read back.
   task automatic t_rmw();
      logic [7:0] op [5] = '{8'h40, 8'h82, 8'h05, 8'hC1, 8'h47};
      logic [7:0] exp [5] = '{8'h25, 8'h20, 8'h04, 8'h24, 8'h24};
      @(posedge clk_sys);
      board_level <= 6'h24;
      for (int i = 0; i < 5; i++) begin
         wr(`PA_ADDR_BIT_MODIFY, op[i]);
         rd_chk(`PA_ADDR_LATCH, exp[i]);
      end
   endtask

   task automatic t_analog_out();
      wr(`PA_ADDR_ANALOG, 8'h3F);
      wr(`PA_ADDR_LATCH, 8'h21);
      wr(`PA_ADDR_DIRECTION, 8'h00);
      settle();
      check({2'h0, pin_oe}, 8'h37);
      check({2'h0, pin_out}, 8'h21);
      rd_chk(`PA_ADDR_PIN_VALUE, 8'h00);
      wr(`PA_ADDR_DIRECTION, 8'h3F);
      wr(`PA_ADDR_ANALOG, 8'h00);
   endtask

   task automatic t_steer();
      wr(`PA_ADDR_DIRECTION, 8'h00);
      wr(`PA_ADDR_LATCH, 8'h00);
      eccp2_output_b <= 1'b1;
      eccp2_output_b_en <= 1'b1;
      capture2_out <= 1'b1;
      capture2_en <= 1'b1;
      wr(`PA_ADDR_ALT_PIN, 8'hFF);
      settle();
      rd_chk(`PA_ADDR_ALT_PIN, 8'h3F);
      check({2'h0, serial_out2_pin_select, slave_select2_pin_select, eccp1_d_pin_select,
         eccp1_c_pin_select, eccp2_b_pin_select, capture2_pin_select}, 8'h3F);
      check({2'h0, pin_out[5:4], portc_line_two_en, portc_line_two_out, capture2_dflt_en,
         capture2_dflt_out}, 8'h30);
      check({2'h0, pin_oe}, 8'h37);
      @(posedge clk_sys);
      line_four_prio_en <= 4'h5;
      line_four_prio_val <= 4'h4;
      settle();
      check({7'h00, pin_out[4]}, 8'h00);
      @(posedge clk_sys);
      line_four_prio_en <= 4'h0;
      wr(`PA_ADDR_ALT_PIN, 8'h00);
      settle();
      check({2'h0, pin_out[5:4], portc_line_two_en, portc_line_two_out,
         capture2_dflt_en, capture2_dflt_out}, 8'h0F);
      check({2'h0, pin_oe}, 8'h37);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      t_reset();
      t_drive();
      t_read();
      t_rmw();
      t_analog_out();
      t_steer();
      results();
   end
endmodule
